// >>> design/hub_port_charge_removable_cfg.v
// charge-port enable and removable configuration registers of a four-port hub
`timescale 1ns/1ps
`include "hub_cfg_map.vh"

module hub_port_charge_removable_cfg #(
	parameter PORTS = 4
) (
	// clock and reset
	input wire SYS_CLK,
	input wire RSTN,
	// strap pins, sampled after reset release
	input wire [PORTS-1:0] POWER_ON_CHARGE_STRAP,
	input wire [PORTS-1:0] AMBER_LED_REMOVABLE_STRAP,
	// configuration mode and port-used field from the hub core
	input wire [`CFG_MODE_W-1:0] CFG_MODE,
	input wire [PORTS-1:0] PORT_USED,
	// configuration access from the EEPROM loader or SMBus slave
	input wire CFG_WR,
	input wire CFG_RD,
	input wire [`CFG_ADDR_W-1:0] CFG_ADDR,
	input wire [`CFG_DATA_W-1:0] CFG_WDATA,
	output reg [`CFG_DATA_W-1:0] CFG_RDATA,
	output reg CFG_RVALID,
	output reg CFG_READY,
	// per-port configuration towards the port logic
	output reg [PORTS-1:0] CHARGE_PORT_ENABLE,
	output reg [PORTS-1:0] PORT_REMOVABLE
);

	// ************************************************************
	// state
	// ************************************************************
	localparam ST_STRAP = 1'b0;
	localparam ST_RUN = 1'b1;

	reg state;
	reg next_state;
	reg [PORTS-1:0] charge_port_enable;
	reg [PORTS-1:0] port_removable;
	reg [PORTS-1:0] next_charge_port_enable;
	reg [PORTS-1:0] next_port_removable;
	reg [`CFG_DATA_W-1:0] next_rdata;

	wire [PORTS-1:0] charge_strap;
	wire [PORTS-1:0] removable_strap;
	wire charge_strap_done;
	wire removable_strap_done;
	wire strap_done;
	wire host_mode;
	wire wr_charge;
	wire wr_removable;
	wire [PORTS-1:0] wr_field;
	wire addr_charge;
	wire addr_removable;
	wire wr_allowed;
	wire [PORTS-1:0] charge_merge;

	genvar n;

	// ************************************************************
	// strap capture
	// ************************************************************
	strap_capture #(
		.WIDTH(PORTS)
	) u_charge_strap (
		.clk(SYS_CLK),
		.rstn(RSTN),
		.strap(POWER_ON_CHARGE_STRAP),
		.value(charge_strap),
		.captured(charge_strap_done)
	);

	strap_capture #(
		.WIDTH(PORTS)
	) u_removable_strap (
		.clk(SYS_CLK),
		.rstn(RSTN),
		.strap(AMBER_LED_REMOVABLE_STRAP),
		.value(removable_strap),
		.captured(removable_strap_done)
	);

	// the straps pass two flops and a short settle count, so they must hold steady for
	// about four clocks after reset release; the fields load on the fourth edge
	assign strap_done = charge_strap_done & removable_strap_done;

	// ************************************************************
	// access decode
	// ************************************************************
	// in pin mode the straps are final; the serial side cannot change them
	assign host_mode = (CFG_MODE == `CFG_MODE_I2C) || (CFG_MODE == `CFG_MODE_SMBUS);
	assign addr_charge = (CFG_ADDR == `CFG_ADDR_CHARGE_PORT_ENABLE);
	assign addr_removable = (CFG_ADDR == `CFG_ADDR_PORT_REMOVABLE);
	// a write before the strap load would be overwritten by the straps, so it is refused
	assign wr_allowed = CFG_WR && host_mode && (state == ST_RUN);
	assign wr_charge = wr_allowed && addr_charge;
	assign wr_removable = wr_allowed && addr_removable;
	// upper data bits are simply not routed anywhere
	assign wr_field = CFG_WDATA[`PORT_FIELD_MSB:`PORT_FIELD_LSB];

	// ************************************************************
	// per-port charge write merge
	// ************************************************************
	// a port marked unused keeps its current charge bit whatever the host writes
	generate
		for (n = 0; n < PORTS; n = n + 1) begin : g_port
			assign charge_merge[n] = PORT_USED[n] ? wr_field[n] : charge_port_enable[n];
		end
	endgenerate

	// ************************************************************
	// next-state logic
	// ************************************************************
	always @* begin
		next_state = state;
		next_charge_port_enable = charge_port_enable;
		next_port_removable = port_removable;
		case (state)
			ST_STRAP: begin
				if (strap_done) begin
					next_charge_port_enable = charge_strap;
					next_port_removable = removable_strap;
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (wr_charge) begin
					next_charge_port_enable = charge_merge;
				end
				if (wr_removable) begin
					next_port_removable = wr_field;
				end
			end
			default: begin
				next_state = ST_STRAP;
			end
		endcase
	end

	// ************************************************************
	// read mux
	// ************************************************************
	// unmapped offsets read zero; a read in the write cycle sees the old value
	always @* begin
		next_rdata = `CFG_DATA_RESET;
		case (CFG_ADDR)
			`CFG_ADDR_CHARGE_PORT_ENABLE: begin
				next_rdata = {`RSVD_READ_VALUE, charge_port_enable};
			end
			`CFG_ADDR_PORT_REMOVABLE: begin
				next_rdata = {`RSVD_READ_VALUE, port_removable};
			end
			default: begin
				next_rdata = `CFG_DATA_RESET;
			end
		endcase
	end

	// ************************************************************
	// registers
	// ************************************************************
	always @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state <= ST_STRAP;
		end else begin
			state <= next_state;
		end
	end

	always @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			charge_port_enable <= `PORT_FIELD_RESET;
			port_removable <= `PORT_FIELD_RESET;
		end else begin
			charge_port_enable <= next_charge_port_enable;
			port_removable <= next_port_removable;
		end
	end

	always @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			CFG_RDATA <= `CFG_DATA_RESET;
			CFG_RVALID <= 1'b0;
		end else begin
			CFG_RVALID <= CFG_RD;
			if (CFG_RD) begin
				CFG_RDATA <= next_rdata;
			end
		end
	end

	// ************************************************************
	// ready flag
	// ************************************************************
	// rises on the edge that loads the straps, so it always matches the state term of the write gate
	always @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			CFG_READY <= 1'b0;
		end else begin
			CFG_READY <= (next_state == ST_RUN);
		end
	end

	// ************************************************************
	// field outputs, each from its own flop
	// ************************************************************
	// the outputs follow next_ values so they change in the same cycle as the registers
	always @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			CHARGE_PORT_ENABLE <= `PORT_FIELD_RESET;
			PORT_REMOVABLE <= `PORT_FIELD_RESET;
		end else begin
			CHARGE_PORT_ENABLE <= next_charge_port_enable;
			PORT_REMOVABLE <= next_port_removable;
		end
	end

endmodule

// >>> include/hub_cfg_map.vh
// address map, field layout, reset values and mode codes of the port configuration registers
`ifndef HUB_CFG_MAP_VH
`define HUB_CFG_MAP_VH

// ************************************************************
// register offsets in the configuration space
// ************************************************************
`define CFG_ADDR_W 8
`define CFG_DATA_W 8
`define CFG_ADDR_CHARGE_PORT_ENABLE 8'h06
`define CFG_ADDR_PORT_REMOVABLE 8'h07

// ************************************************************
// field layout
// ************************************************************
`define PORT_FIELD_MSB 3
`define PORT_FIELD_LSB 0
`define PORT_FIELD_W 4
`define RSVD_FIELD_MSB 7
`define RSVD_FIELD_LSB 4
`define RSVD_READ_VALUE 4'h0

// ************************************************************
// reset values; the port fields hold theirs only until the straps are captured
// ************************************************************
`define PORT_FIELD_RESET 4'h0
`define CFG_DATA_RESET 8'h00

// ************************************************************
// configuration modes
// ************************************************************
`define CFG_MODE_W 2
`define CFG_MODE_PIN 2'h0
`define CFG_MODE_I2C 2'h1
`define CFG_MODE_SMBUS 2'h2

// ************************************************************
// strap capture
// ************************************************************
`define STRAP_SYNC_STAGES 2
`define STRAP_SETTLE_W 2
`define STRAP_SETTLE_CYCLES 2'h2

`endif

// >>> design/strap_capture.v
// strap synchroniser that captures pin levels once after reset release
`timescale 1ns/1ps
`include "hub_cfg_map.vh"

module strap_capture #(
	parameter WIDTH = 4
) (
	// clock and reset
	input wire clk,
	input wire rstn,
	// strap pins
	input wire [WIDTH-1:0] strap,
	// captured value
	output reg [WIDTH-1:0] value,
	output reg captured
);

	reg [WIDTH-1:0] sync_a;
	reg [WIDTH-1:0] sync_b;
	reg [`STRAP_SETTLE_W-1:0] settle;

	// ************************************************************
	// two-stage synchroniser; only sync_b is read
	// ************************************************************
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync_a <= {WIDTH{1'b0}};
			sync_b <= {WIDTH{1'b0}};
		end else begin
			sync_a <= strap;
			sync_b <= sync_a;
		end
	end

	// ************************************************************
	// capture once the synchroniser holds post-release pin levels
	// ************************************************************
	// the straps are sampled by a clocked process after release, never by the reset itself
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			settle <= {`STRAP_SETTLE_W{1'b0}};
			value <= {WIDTH{1'b0}};
			captured <= 1'b0;
		end else if (!captured) begin
			if (settle == `STRAP_SETTLE_CYCLES) begin
				value <= sync_b;
				captured <= 1'b1;
			end else begin
				settle <= settle + {{(`STRAP_SETTLE_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

// >>> testbench/cfg_checker.sv
// assertions on the port configuration register block
`timescale 1ns/1ps
`include "hub_cfg_map.vh"
module cfg_checker #(parameter PORTS = 4) (
	// every port of the register block
	input wire SYS_CLK,
	input wire RSTN,
	input wire [PORTS-1:0] POWER_ON_CHARGE_STRAP,
	input wire [PORTS-1:0] AMBER_LED_REMOVABLE_STRAP,
	input wire [`CFG_MODE_W-1:0] CFG_MODE,
	input wire [PORTS-1:0] PORT_USED,
	input wire CFG_WR,
	input wire CFG_RD,
	input wire [`CFG_ADDR_W-1:0] CFG_ADDR,
	input wire [`CFG_DATA_W-1:0] CFG_WDATA,
	input wire [`CFG_DATA_W-1:0] CFG_RDATA,
	input wire CFG_RVALID,
	input wire CFG_READY,
	input wire [PORTS-1:0] CHARGE_PORT_ENABLE,
	input wire [PORTS-1:0] PORT_REMOVABLE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	wire wr_ok;
	assign wr_ok = CFG_WR && CFG_READY && (CFG_MODE == 2'h1 || CFG_MODE == 2'h2);
	rsvd_zero_a: assert property (CFG_RVALID |-> CFG_RDATA[7:4] == 4'h0)
		else $error("reserved bits read nonzero");
	rd_valid_a: assert property (CFG_RD |=> CFG_RVALID)
		else $error("read not answered");
	valid_cause_a: assert property (CFG_RVALID |-> $past(CFG_RD))
		else $error("read answer without request");
	rd_charge_a: assert property (CFG_RD && CFG_ADDR == 8'h06
		|=> CFG_RDATA[3:0] == $past(CHARGE_PORT_ENABLE)) else $error("charge read wrong");
	rd_rem_a: assert property (CFG_RD && CFG_ADDR == 8'h07
		|=> CFG_RDATA[3:0] == $past(PORT_REMOVABLE)) else $error("removable read wrong");
	charge_wr_a: assert property (wr_ok && CFG_ADDR == 8'h06 |=> CHARGE_PORT_ENABLE ==
		(($past(CHARGE_PORT_ENABLE) & ~$past(PORT_USED)) | ($past(CFG_WDATA[3:0]) & $past(PORT_USED))))
		else $error("charge write wrong");
	rem_wr_a: assert property (wr_ok && CFG_ADDR == 8'h07
		|=> PORT_REMOVABLE == $past(CFG_WDATA[3:0])) else $error("removable write wrong");
	pin_hold_a: assert property (CFG_READY && !wr_ok
		|=> $stable(CHARGE_PORT_ENABLE) && $stable(PORT_REMOVABLE)) else $error("field changed");
	strap_load_a: assert property ($rose(CFG_READY) |-> CHARGE_PORT_ENABLE ==
		POWER_ON_CHARGE_STRAP && PORT_REMOVABLE == AMBER_LED_REMOVABLE_STRAP)
		else $error("straps not loaded");
endmodule

// >>> testbench/cfg_host.sv
// register access master standing in for the eeprom loader or smbus host
`timescale 1ns/1ps
module cfg_host (
	// clock
	input wire clk,
	// register access
	output reg wr = 0,
	output reg rd = 0,
	output reg [7:0] addr = 8'h00,
	output reg [7:0] wdata = 8'h00,
	input wire [7:0] rdata
);
	// released address and data lines show the inverse so stale values never look valid
	task acc(input w, input [7:0] a, input [7:0] d, output [7:0] q);
		begin
			@(posedge clk);
			#1;
			wr = w;
			rd = !w;
			addr = a;
			wdata = d;
			@(posedge clk);
			#1;
			q = rdata;
			wr = 0;
			rd = 0;
			addr = ~a;
			wdata = ~d;
		end
	endtask
endmodule

// >>> testbench/tb.sv
// self-checking bench for the port configuration registers
`timescale 1ns/1ps
`include "hub_cfg_map.vh"
module tb;
	localparam PORTS = 4;
	reg SYS_CLK = 0;
	reg RSTN = 0;
	reg [3:0] chg_strap = 4'h0, rm_strap = 4'h0, used = 4'h0, e_chg, e_rm;
	reg [1:0] mode = 2'h0;
	reg [7:0] q;
	wire wr, rd, rvalid, ready;
	wire [7:0] addr, wdata, rdata;
	wire [3:0] chg, rm;
	integer seed = 20, n_mismatch = 0, checks_done = 0, cyc = 0, i, r;
	always #4 SYS_CLK = ~SYS_CLK;
	cfg_host host (.clk(SYS_CLK), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata));
	hub_port_charge_removable_cfg #(.PORTS(PORTS)) uut (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
		.POWER_ON_CHARGE_STRAP(chg_strap), .AMBER_LED_REMOVABLE_STRAP(rm_strap),
		.CFG_MODE(mode), .PORT_USED(used), .CFG_WR(wr), .CFG_RD(rd), .CFG_ADDR(addr),
		.CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_RVALID(rvalid), .CFG_READY(ready),
		.CHARGE_PORT_ENABLE(chg), .PORT_REMOVABLE(rm));
	function [3:0] upd(input [3:0] old, input [3:0] d, input [3:0] mask, input [1:0] m);
		upd = (m == `CFG_MODE_I2C || m == `CFG_MODE_SMBUS) ? (old & ~mask) | (d & mask) : old;
	endfunction
	task cmp(input [63:0] name, input [7:0] e, input [7:0] g);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("wrong value %0s expected %h seen %h", name, e, g);
			end
		end
	endtask
	task stop_test;
		begin
			$display("mismatches %0d checks %0d", n_mismatch, checks_done);
			if (n_mismatch == 0 && checks_done > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	always @(posedge SYS_CLK) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			n_mismatch = n_mismatch + 1;
			stop_test;
		end
	end
	task check_all;
		begin
			cmp("chg out", {4'h0, e_chg}, {4'h0, chg});
			cmp("rem out", {4'h0, e_rm}, {4'h0, rm});
			host.acc(0, `CFG_ADDR_CHARGE_PORT_ENABLE, 8'h00, q);
			cmp("chg rd", {4'h0, e_chg}, q);
			host.acc(0, `CFG_ADDR_PORT_REMOVABLE, 8'h00, q);
			cmp("rem rd", {4'h0, e_rm}, q);
		end
	endtask
	// a write issued before ready must be dropped
	task do_reset;
		begin
			RSTN = 0;
			r = $random(seed);
			chg_strap = r[3:0];
			rm_strap = r[7:4];
			mode = `CFG_MODE_I2C;
			used = 4'hf;
			repeat (5) @(posedge SYS_CLK);
			#1;
			RSTN = 1;
			host.acc(1, `CFG_ADDR_CHARGE_PORT_ENABLE, ~{4'h0, chg_strap}, q);
			r = 0;
			while (ready !== 1'b1 && r < 20) begin
				@(posedge SYS_CLK);
				#1;
				r = r + 1;
			end
			cmp("ready", 8'h01, {7'h0, ready});
			e_chg = chg_strap;
			e_rm = rm_strap;
			check_all;
		end
	endtask
	initial begin
		do_reset;
		for (i = 0; i < 40; i = i + 1) begin
			r = $random(seed);
			mode = (i < 4) ? `CFG_MODE_SMBUS : r[1:0];
			used = (i < 4) ? 4'h1 << i : r[5:2];
			host.acc(1, `CFG_ADDR_CHARGE_PORT_ENABLE, r[15:8], q);
			e_chg = upd(e_chg, r[11:8], used, mode);
			host.acc(1, `CFG_ADDR_PORT_REMOVABLE, r[23:16], q);
			e_rm = upd(e_rm, r[19:16], 4'hf, mode);
			check_all;
			host.acc(1, 8'h08, r[31:24], q);
			host.acc(0, 8'h08, 8'h00, q);
			cmp("unmapped", 8'h00, q);
			if (i == 20)
				do_reset;
		end
		stop_test;
	end
endmodule
bind hub_port_charge_removable_cfg cfg_checker #(.PORTS(PORTS)) chk (.SYS_CLK(SYS_CLK),
	.RSTN(RSTN), .POWER_ON_CHARGE_STRAP(POWER_ON_CHARGE_STRAP),
	.AMBER_LED_REMOVABLE_STRAP(AMBER_LED_REMOVABLE_STRAP), .CFG_MODE(CFG_MODE),
	.PORT_USED(PORT_USED), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR),
	.CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID),
	.CFG_READY(CFG_READY), .CHARGE_PORT_ENABLE(CHARGE_PORT_ENABLE),
	.PORT_REMOVABLE(PORT_REMOVABLE));
